// file: src/rtcatc_time_control.sv
// Alarm registers, time control register and alarm event logic
module rtcatc_time_control
  import rtcatc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // 32kHz timing and counter rollovers
  input wire logic rtc_tick,
  input wire logic sec_roll,
  input wire logic min_roll,
  input wire logic hour_roll,
  input wire logic day_roll,
  input wire logic month_roll,
  // Current time
  input wire logic [6:0] cur_seconds,
  input wire logic [6:0] cur_minutes,
  input wire logic [5:0] current_hour,
  input wire logic [2:0] cur_weekday,
  input wire logic [5:0] cur_day_of_month,
  input wire logic [4:0] cur_month,
  // Control to counters
  output logic counter_halt,
  output logic bcd_sel,
  output logic twelve_hour_sel,
  // Events
  output logic alarm_event,
  output logic periodic_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [6:0] alarm_seconds;
    logic [6:0] alarm_minutes;
    logic [4:0] alarm_hour;
    logic alarm_pm_flag;
    logic [3:0] alarm_weekday;
    logic [5:0] alarm_day_of_month;
    logic [4:0] alarm_month;
    logic bcd;
    logic twelve;
    logic set_req;
    logic alarm_halt_req;
    logic [2:0] periodic_irq_rate;
    logic counter_halted;
    logic alarm_halted;
    logic match_prev;
    logic alarm_event;
    logic [15:0] rdata;
  } rtcatc_state_t;

  localparam rtcatc_state_t RTCATC_RST_STATE = '{
    alarm_seconds: RTCATC_RST_SEC,
    alarm_minutes: RTCATC_RST_MIN,
    alarm_hour: RTCATC_RST_HOUR,
    alarm_pm_flag: RTCATC_RST_PM,
    alarm_weekday: RTCATC_RST_WDAY,
    alarm_day_of_month: RTCATC_RST_DOM,
    alarm_month: RTCATC_RST_MON,
    bcd: RTCATC_RST_BCD,
    twelve: RTCATC_RST_12HR,
    set_req: RTCATC_RST_SET,
    alarm_halt_req: RTCATC_RST_ALMSET,
    periodic_irq_rate: RTCATC_RST_RATE,
    counter_halted: RTCATC_RST_STS,
    alarm_halted: RTCATC_RST_ALMSTS,
    match_prev: 1'b0,
    alarm_event: 1'b0,
    rdata: 16'h0000
  };

  rtcatc_state_t s_q, s_d;
  logic match;
  logic [5:0] hour_seen;

  // ----------------------------------------------------------------
  // Read composition
  // ----------------------------------------------------------------
  // Unused and reserved bits read as zero
  function automatic logic [15:0] read_word(input rtcatc_state_t s,
                                            input logic [7:0] addr);
    logic [15:0] w;
    w = 16'h0000;
    unique case (addr)
      RTCATC_OFS_ALARM_SEC_MIN: begin
        w[RTCATC_SEC_LSB +: 7] = s.alarm_seconds;
        w[RTCATC_MIN_LSB +: 7] = s.alarm_minutes;
      end
      RTCATC_OFS_ALARM_HOURS_WEEKDAY: begin
        w[RTCATC_HOUR_LSB +: 5] = s.alarm_hour;
        w[RTCATC_PM_BIT] = s.alarm_pm_flag;
        w[RTCATC_WDAY_LSB +: 4] = s.alarm_weekday;
      end
      RTCATC_OFS_ALARM_DATE_MONTH: begin
        w[RTCATC_DOM_LSB +: 6] = s.alarm_day_of_month;
        w[RTCATC_MON_LSB +: 5] = s.alarm_month;
      end
      RTCATC_OFS_CLOCK_TIME_CONTROL: begin
        w[RTCATC_BCD_BIT] = s.bcd;
        w[RTCATC_12HR_BIT] = s.twelve;
        w[RTCATC_SET_BIT] = s.set_req;
        w[RTCATC_STS_BIT] = s.counter_halted;
        w[RTCATC_ALMSET_BIT] = s.alarm_halt_req;
        w[RTCATC_ALMSTS_BIT] = s.alarm_halted;
        w[RTCATC_RATE_LSB +: 3] = s.periodic_irq_rate;
      end
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Alarm compare
  // ----------------------------------------------------------------
  // 24h top bit zero
  assign hour_seen = s_q.twelve ? current_hour :
                     {1'b0, current_hour[4:0]};

  rtcatc_alarm_match u_match (
    .alarm_seconds(s_q.alarm_seconds),
    .alarm_minutes(s_q.alarm_minutes),
    .alarm_hour(s_q.alarm_hour),
    .alarm_pm_flag(s_q.alarm_pm_flag),
    .alarm_weekday(s_q.alarm_weekday),
    .alarm_day_of_month(s_q.alarm_day_of_month),
    .alarm_month(s_q.alarm_month),
    .twelve_hour_sel(s_q.twelve),
    .cur_seconds(cur_seconds),
    .cur_minutes(cur_minutes),
    .current_hour(hour_seen),
    .cur_weekday(cur_weekday),
    .cur_day_of_month(cur_day_of_month),
    .cur_month(cur_month),
    .match(match)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.alarm_event = 1'b0;
    if (reg_rd) begin
      s_d.rdata = read_word(s_q, reg_addr);
    end
    if (reg_wr) begin
      unique case (reg_addr)
        RTCATC_OFS_ALARM_SEC_MIN: begin
          s_d.alarm_seconds = reg_wdata[RTCATC_SEC_LSB +: 7];
          s_d.alarm_minutes = reg_wdata[RTCATC_MIN_LSB +: 7];
        end
        RTCATC_OFS_ALARM_HOURS_WEEKDAY: begin
          s_d.alarm_hour = reg_wdata[RTCATC_HOUR_LSB +: 5];
          s_d.alarm_pm_flag = reg_wdata[RTCATC_PM_BIT];
          s_d.alarm_weekday = reg_wdata[RTCATC_WDAY_LSB +: 4];
        end
        RTCATC_OFS_ALARM_DATE_MONTH: begin
          s_d.alarm_day_of_month = reg_wdata[RTCATC_DOM_LSB +: 6];
          s_d.alarm_month = reg_wdata[RTCATC_MON_LSB +: 5];
        end
        RTCATC_OFS_CLOCK_TIME_CONTROL: begin
          s_d.bcd = reg_wdata[RTCATC_BCD_BIT];
          s_d.twelve = reg_wdata[RTCATC_12HR_BIT];
          s_d.set_req = reg_wdata[RTCATC_SET_BIT];
          s_d.alarm_halt_req = reg_wdata[RTCATC_ALMSET_BIT];
          s_d.periodic_irq_rate = reg_wdata[RTCATC_RATE_LSB +: 3];
        end
        default: begin
          s_d.rdata = s_d.rdata;
        end
      endcase
    end
    // Requests are sampled at the tick so the counters never see a
    // stop in the middle of a 32kHz period
    if (rtc_tick) begin
      s_d.counter_halted = s_q.set_req;
      s_d.alarm_halted = s_q.alarm_halt_req;
      s_d.match_prev = match;
      s_d.alarm_event = match && !s_q.match_prev && !s_q.alarm_halted;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= RTCATC_RST_STATE;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Periodic pulse
  // ----------------------------------------------------------------
  rtcatc_periodic u_periodic (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .rtc_tick(rtc_tick),
    .sec_roll(sec_roll),
    .min_roll(min_roll),
    .hour_roll(hour_roll),
    .day_roll(day_roll),
    .month_roll(month_roll),
    .periodic_irq_rate(s_q.periodic_irq_rate),
    .counter_halted(s_q.counter_halted),
    .periodic_irq(periodic_irq)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = s_q.rdata;
  assign counter_halt = s_q.counter_halted;
  assign bcd_sel = s_q.bcd;
  assign twelve_hour_sel = s_q.twelve;
  assign alarm_event = s_q.alarm_event;

endmodule

// file: shared/rtcatc_pkg.sv
// Constants for the alarm-compare and time-control logic of the clock
package rtcatc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RTCATC_OFS_ALARM_SEC_MIN = 8'h14;
  localparam logic [7:0] RTCATC_OFS_ALARM_HOURS_WEEKDAY = 8'h15;
  localparam logic [7:0] RTCATC_OFS_ALARM_DATE_MONTH = 8'h16;
  localparam logic [7:0] RTCATC_OFS_CLOCK_TIME_CONTROL = 8'h17;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RTCATC_SEC_LSB = 0;
  localparam int RTCATC_MIN_LSB = 8;
  localparam int RTCATC_HOUR_LSB = 0;
  localparam int RTCATC_PM_BIT = 5;
  localparam int RTCATC_WDAY_LSB = 8;
  localparam int RTCATC_DOM_LSB = 0;
  localparam int RTCATC_MON_LSB = 8;
  localparam int RTCATC_BCD_BIT = 15;
  localparam int RTCATC_12HR_BIT = 14;
  localparam int RTCATC_SET_BIT = 11;
  localparam int RTCATC_STS_BIT = 10;
  localparam int RTCATC_ALMSET_BIT = 9;
  localparam int RTCATC_ALMSTS_BIT = 8;
  localparam int RTCATC_RATE_LSB = 4;

  // ----------------------------------------------------------------
  // Don't-care codes (all ones in each field)
  // ----------------------------------------------------------------
  localparam logic [6:0] RTCATC_DC_SEC = 7'h7f;
  localparam logic [6:0] RTCATC_DC_MIN = 7'h7f;
  localparam logic [4:0] RTCATC_DC_HOUR = 5'h1f;
  localparam logic [3:0] RTCATC_DC_WDAY = 4'hf;
  localparam logic [5:0] RTCATC_DC_DOM = 6'h3f;
  localparam logic [4:0] RTCATC_DC_MON = 5'h1f;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [6:0] RTCATC_RST_SEC = 7'h00;
  localparam logic [6:0] RTCATC_RST_MIN = 7'h00;
  localparam logic [4:0] RTCATC_RST_HOUR = 5'h00;
  localparam logic RTCATC_RST_PM = 1'b0;
  localparam logic [3:0] RTCATC_RST_WDAY = 4'h0;
  localparam logic [5:0] RTCATC_RST_DOM = 6'h00;
  localparam logic [4:0] RTCATC_RST_MON = 5'h00;
  localparam logic RTCATC_RST_BCD = 1'b0;
  localparam logic RTCATC_RST_12HR = 1'b0;
  localparam logic RTCATC_RST_SET = 1'b0;
  localparam logic RTCATC_RST_STS = 1'b0;
  localparam logic RTCATC_RST_ALMSET = 1'b1;
  localparam logic RTCATC_RST_ALMSTS = 1'b1;
  localparam logic [2:0] RTCATC_RST_RATE = 3'h2;

  // ----------------------------------------------------------------
  // Periodic rate codes
  // ----------------------------------------------------------------
  localparam logic [2:0] RTCATC_RATE_OFF = 3'h0;
  localparam logic [2:0] RTCATC_RATE_SEC = 3'h1;
  localparam logic [2:0] RTCATC_RATE_MIN = 3'h2;
  localparam logic [2:0] RTCATC_RATE_HOUR = 3'h3;
  localparam logic [2:0] RTCATC_RATE_DAY = 3'h4;
  localparam logic [2:0] RTCATC_RATE_MONTH = 3'h5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int RTCATC_RTC_CLK_HZ = 32768;
  localparam int RTCATC_SYS_CLK_HZ = 100000000;

endpackage

// file: src/rtcatc_alarm_match.sv
// Combinational alarm comparison with per-field don't care
module rtcatc_alarm_match
  import rtcatc_pkg::*;
(
  // Alarm settings
  input wire logic [6:0] alarm_seconds,
  input wire logic [6:0] alarm_minutes,
  input wire logic [4:0] alarm_hour,
  input wire logic alarm_pm_flag,
  input wire logic [3:0] alarm_weekday,
  input wire logic [5:0] alarm_day_of_month,
  input wire logic [4:0] alarm_month,
  input wire logic twelve_hour_sel,
  // Current time
  input wire logic [6:0] cur_seconds,
  input wire logic [6:0] cur_minutes,
  input wire logic [5:0] current_hour,
  input wire logic [2:0] cur_weekday,
  input wire logic [5:0] cur_day_of_month,
  input wire logic [4:0] cur_month,
  // Result
  output logic match
);

  // ----------------------------------------------------------------
  // Field compare
  // ----------------------------------------------------------------
  // Equality is coding agnostic, so binary and BCD compare alike
  function automatic logic field_hit(input logic [6:0] alm,
                                     input logic [6:0] cur,
                                     input logic [6:0] dc);
    field_hit = (alm == dc) || (alm == cur);
  endfunction

  logic hour_hit;
  logic pm_hit;

  always_comb begin
    hour_hit = field_hit({2'b00, alarm_hour}, {2'b00, current_hour[4:0]},
                         {2'b00, RTCATC_DC_HOUR});
    pm_hit = !twelve_hour_sel || (alarm_hour == RTCATC_DC_HOUR) ||
             (alarm_pm_flag == current_hour[RTCATC_PM_BIT]);
    match = field_hit(alarm_seconds, cur_seconds, RTCATC_DC_SEC) &&
            field_hit(alarm_minutes, cur_minutes, RTCATC_DC_MIN) &&
            hour_hit && pm_hit &&
            field_hit({3'b000, alarm_weekday}, {4'b0000, cur_weekday},
                      {3'b000, RTCATC_DC_WDAY}) &&
            field_hit({1'b0, alarm_day_of_month}, {1'b0, cur_day_of_month},
                      {1'b0, RTCATC_DC_DOM}) &&
            field_hit({2'b00, alarm_month}, {2'b00, cur_month},
                      {2'b00, RTCATC_DC_MON});
  end

endmodule

// file: src/rtcatc_periodic.sv
// Periodic interrupt pulse generator, one 32kHz period wide
module rtcatc_periodic
  import rtcatc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Timing
  input wire logic rtc_tick,
  input wire logic sec_roll,
  input wire logic min_roll,
  input wire logic hour_roll,
  input wire logic day_roll,
  input wire logic month_roll,
  // Control
  input wire logic [2:0] periodic_irq_rate,
  input wire logic counter_halted,
  // Pulse
  output logic periodic_irq
);

  typedef struct packed {
    logic pending;
    logic pulse;
  } rtcatc_per_t;

  rtcatc_per_t s_q, s_d;
  logic roll_sel;

  always_comb begin
    s_d = s_q;
    unique case (periodic_irq_rate)
      RTCATC_RATE_SEC: roll_sel = sec_roll;
      RTCATC_RATE_MIN: roll_sel = min_roll;
      RTCATC_RATE_HOUR: roll_sel = hour_roll;
      RTCATC_RATE_DAY: roll_sel = day_roll;
      RTCATC_RATE_MONTH: roll_sel = month_roll;
      default: roll_sel = 1'b0;
    endcase
    // Pulse spans tick to tick, so it lasts one 32kHz period
    if (rtc_tick) begin
      s_d.pulse = s_q.pending && !counter_halted;
      s_d.pending = 1'b0;
    end
    // A roll landing on the tick is kept for the next period
    if (roll_sel) begin
      s_d.pending = 1'b1;
    end
    if (counter_halted) begin
      s_d.pending = 1'b0;
      s_d.pulse = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign periodic_irq = s_q.pulse;

endmodule

// file: tb/rtcatc_time_control_props.sv
// Port checker for the alarm and time-control block
module rtcatc_time_control_props
  import rtcatc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // Timing
  input wire logic rtc_tick,
  // Outputs
  input wire logic counter_halt,
  input wire logic bcd_sel,
  input wire logic twelve_hour_sel,
  input wire logic alarm_event,
  input wire logic periodic_irq
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic tk;
  logic [1:0] mode_w;
  assign tk = rtc_tick && ce;
  assign mode_w = reg_wdata[15:14];

  a_halt_at_tick: assert property (
    $changed(counter_halt) |-> $past(tk)) else $error("halt moved off tick");
  a_event_one_cycle: assert property (
    alarm_event && ce |=> !alarm_event) else $error("alarm event too long");
  a_event_at_tick: assert property (
    $rose(alarm_event) |-> $past(tk)) else $error("alarm event off tick");
  a_irq_at_tick: assert property (
    $changed(periodic_irq) |-> $past(tk) || counter_halt)
    else $error("periodic pulse edge off tick");
  a_irq_halted: assert property (
    counter_halt [*3] |-> !periodic_irq) else $error("pulse while halted");
  a_rdata_hold: assert property (
    !$past(reg_rd && ce) |-> $stable(reg_rdata)) else $error("rdata moved");
  a_unmapped_zero: assert property (
    reg_rd && ce && (reg_addr < 8'h14 || reg_addr > 8'h17)
    |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  a_ctl_reserved: assert property (
    reg_rd && ce && reg_addr == 8'h17 |=> (reg_rdata & 16'h308f) == 16'h0)
    else $error("reserved control bits set");
  a_mode_write: assert property (
    reg_wr && ce && reg_addr == 8'h17
    |=> {bcd_sel, twelve_hour_sel} == $past(mode_w))
    else $error("mode outputs not updated");
  a_halt_readback: assert property (
    reg_rd && ce && !tk && reg_addr == 8'h17
    |=> reg_rdata[10] == counter_halt) else $error("halt status mismatch");
  a_freeze_outputs: assert property (
    !ce |=> $stable({counter_halt, bcd_sel, twelve_hour_sel, alarm_event,
                     periodic_irq, reg_rdata})) else $error("moved with ce low");
  c_alarm: cover property ($rose(alarm_event));
  c_periodic: cover property ($rose(periodic_irq));
  c_halt: cover property ($rose(counter_halt));
endmodule

bind rtcatc_time_control rtcatc_time_control_props u_props (
  .clk(clk), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .rtc_tick(rtc_tick), .counter_halt(counter_halt), .bcd_sel(bcd_sel),
  .twelve_hour_sel(twelve_hour_sel), .alarm_event(alarm_event),
  .periodic_irq(periodic_irq));

// file: tb/rtcatc_time_control_tb.sv
// Self-checking bench for the alarm and time-control block
module rtcatc_time_control_tb import rtcatc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic rtc_tick = 1'b0;
  logic [4:0] rolls = 5'h00;
  logic [6:0] cur_seconds = 7'h00;
  logic [5:0] current_hour = 6'h00;
  logic counter_halt, bcd_sel, twelve_hour_sel, alarm_event, periodic_irq;
  logic [1:0] tcnt = 2'h0;
  logic irq_q = 1'b0;
  int fail_count = 0;
  int checked = 0;
  int ev_cnt = 0;
  int pr_cnt = 0;
  int hi_cnt = 0;
  logic [15:0] d;
  logic [6:0] s;

  // Minutes, weekday, date and month held fixed; alarms always mask the minutes
  rtcatc_time_control DUT (.clk(clk), .rst(rst), .ce(ce), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .rtc_tick(rtc_tick), .sec_roll(rolls[0]),
    .min_roll(rolls[1]), .hour_roll(rolls[2]), .day_roll(rolls[3]),
    .month_roll(rolls[4]), .cur_seconds(cur_seconds),
    .cur_minutes(7'h00), .current_hour(current_hour),
    .cur_weekday(3'h1), .cur_day_of_month(6'h01), .cur_month(5'h01),
    .counter_halt(counter_halt), .bcd_sel(bcd_sel),
    .twelve_hour_sel(twelve_hour_sel), .alarm_event(alarm_event),
    .periodic_irq(periodic_irq));

  initial begin
    forever #5 clk = ~clk;
  end

  // ----
  // Slow tick every fourth cycle and event counters
  // ----
  always @(posedge clk) begin
    tcnt <= tcnt + 2'h1;
    rtc_tick <= (tcnt == 2'h3);
    irq_q <= periodic_irq;
    if (alarm_event === 1'b1) ev_cnt <= ev_cnt + 1;
    if (periodic_irq === 1'b1) hi_cnt <= hi_cnt + 1;
    if (periodic_irq === 1'b1 && irq_q === 1'b0) pr_cnt <= pr_cnt + 1;
  end

  function automatic logic [15:0] ctl(input logic b, h, st, al,
                                      input logic [2:0] r);
    return {b, h, 2'b00, st, st, al, al, 1'b0, r, 4'h0};
  endfunction
  function automatic int fires(input logic [2:0] r);
    return (r >= 3'h1 && r <= 3'h5) ? 1 : 0;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, e);
  endtask
  task automatic pulse_roll(input logic [4:0] m);
    pr_cnt = 0;
    hi_cnt = 0;
    @(posedge clk);
    rolls <= m;
    @(posedge clk);
    rolls <= 5'h00;
    wait_n(14);
  endtask
  // Match only on the new seconds value, after a settled mismatch
  task automatic try_alarm(input logic [5:0] h, input int e);
    @(posedge clk);
    cur_seconds <= s ^ 7'h01;
    wait_n(6);
    ev_cnt = 0;
    @(posedge clk);
    cur_seconds <= s;
    current_hour <= h;
    wait_n(10);
    check(16'(ev_cnt), 16'(e));
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic finish_test;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #50us;
    fail_count++;
    finish_test;
  end

  // ----
  // Main sequence
  // ----
  initial begin
    void'($urandom(32'h7ff6));
    do_reset;
    rdchk(8'h14, 16'h0000);
    rdchk(8'h15, 16'h0000);
    rdchk(8'h16, 16'h0000);
    rdchk(8'h17, 16'h0320);
    check({13'h0, counter_halt, bcd_sel, twelve_hour_sel}, 16'h0);
    // Alarms still stopped from reset while fields change
    for (int i = 0; i < 6; i++) begin
      d = 16'($urandom());
      wr(8'h14, d);
      wr(8'h15, d);
      wr(8'h16, d);
      rdchk(8'h14, d & 16'h7f7f);
      rdchk(8'h15, d & 16'h0f3f);
      rdchk(8'h16, d & 16'h1f3f);
    end
    wr(8'h20, 16'hffff);
    rdchk(8'h20, 16'h0000);
    @(posedge clk);
    ce <= 1'b0;
    wr(8'h16, 16'h0000);
    @(posedge clk);
    ce <= 1'b1;
    rdchk(8'h16, d & 16'h1f3f);
    wr(8'h17, 16'h358f);
    wait_n(6);
    rdchk(8'h17, 16'h0000);
    wr(8'h17, ctl(1, 1, 1, 0, 3'h3));
    wait_n(6);
    rdchk(8'h17, ctl(1, 1, 1, 0, 3'h3));
    check({13'h0, counter_halt, bcd_sel, twelve_hour_sel}, 16'h7);
    for (int r = 0; r < 8; r++) begin
      wr(8'h17, ctl(0, 0, 0, 1, 3'(r)));
      wait_n(6);
      pulse_roll(fires(3'(r)) != 0 ? 5'(1 << (r - 1)) : 5'h1f);
      check(16'(pr_cnt), 16'(fires(3'(r))));
      check(16'(hi_cnt), 16'(4 * fires(3'(r))));
    end
    wr(8'h17, ctl(0, 0, 1, 1, 3'h1));
    wait_n(6);
    pulse_roll(5'h01);
    check(16'(pr_cnt), 16'h0000);
    s = 7'($urandom_range(59));
    wr(8'h17, ctl(0, 0, 0, 1, 3'h0));
    wr(8'h14, {1'b0, 7'h7f, 1'b0, s});
    wr(8'h15, 16'h0f3f);
    wr(8'h16, 16'h1f3f);
    wr(8'h17, ctl(0, 0, 0, 0, 3'h0));
    try_alarm(6'h00, 1);
    wr(8'h17, ctl(0, 1, 0, 1, 3'h0));
    wr(8'h15, 16'h0f25);
    wr(8'h17, ctl(0, 1, 0, 0, 3'h0));
    try_alarm(6'h05, 0);
    try_alarm(6'h25, 1);
    // Weekday, date and month cared for against the fixed current time
    wr(8'h17, ctl(0, 1, 0, 1, 3'h0));
    wr(8'h15, 16'h0225);
    wr(8'h17, ctl(0, 1, 0, 0, 3'h0));
    try_alarm(6'h25, 0);
    wr(8'h17, ctl(0, 1, 0, 1, 3'h0));
    wr(8'h15, 16'h0125);
    wr(8'h16, 16'h0101);
    wr(8'h17, ctl(0, 1, 0, 0, 3'h0));
    try_alarm(6'h25, 1);
    wr(8'h17, ctl(0, 1, 0, 1, 3'h0));
    wr(8'h16, 16'h0102);
    wr(8'h17, ctl(0, 1, 0, 0, 3'h0));
    try_alarm(6'h25, 0);
    wr(8'h17, ctl(0, 1, 0, 1, 3'h0));
    wr(8'h16, 16'h0201);
    wr(8'h17, ctl(0, 1, 0, 0, 3'h0));
    try_alarm(6'h25, 0);
    wr(8'h17, ctl(0, 1, 0, 1, 3'h0));
    try_alarm(6'h25, 0);
    do_reset;
    rdchk(8'h17, 16'h0320);
    finish_test;
  end
endmodule
